// >>> hw/uhi_irq_ctrl.sv
`default_nettype none
module uhi_irq_ctrl
  import uhi_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_CYC
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Processor port
  input  wire logic              pioCsN,
  input  wire logic              pioRdN,
  input  wire logic              pioWrN,
  input  wire logic [1:0]        pioAddr,
  input  wire logic [15:0]       pioDataIn,
  output logic      [15:0]       pioDataOut,
  output logic                   pioDataOe,
  // Host events
  input  wire logic [5:0]        hostGroup2Evt,
  input  wire logic [4:0]        hostGroup1Evt,
  // Device events
  input  wire logic              busResetEvt,
  input  wire logic              resumeEvt,
  input  wire logic              suspendEotEvt,
  input  wire logic              eotEvt,
  input  wire logic              sofEvt,
  input  wire logic              busSuspended,
  input  wire logic [NUM_EP-1:0] epAckEvt,
  input  wire logic [NUM_EP-1:0] epIsoEvt,
  input  wire logic [NUM_EP-1:0] epIsoSel,
  // Interrupt pins and suspend
  output logic                   hostIrqPin,
  output logic                   deviceIrqPin,
  output logic                   devSuspendReq
);
  uhi_pio_s pio;
  uhi_pio_s pioQ;

  logic [7:0]  hcIdx;
  logic        hcPhase;
  logic [7:0]  dcIdx;
  logic        dcPhase;

  logic [5:0]  hostStatus;
  logic [31:0] hostIntEn;
  logic [15:0] hostHwCfg;
  logic [15:0] hostCpuFlags;
  logic [15:0] hostCpuEn;
  logic [7:0]  devMode;
  logic [15:0] devHwCfg;
  logic [31:0] devIntEn;
  logic [5:0]  devEvFlags;
  logic [NUM_EP-1:0] epFlags;
  logic [31:0] devFlagView;

  logic        rdFall;
  logic        rdRise;
  logic        wrRise;
  logic        hcWrData;
  logic        dcWrData;
  logic        hcRdDone;
  logic        dcRdDone;
  logic [1:0]  rdPort;
  logic [15:0] rdWord;

  logic        group2Sum;
  logic        group1Or;
  logic        hostLatch;
  logic        hostPulse;
  logic        devPending;
  logic        devActive;
  logic        devPulse;
  logic        pseudoTick;
  logic [$clog2(FRAME_CYCLES)-1:0] frameCnt;
  logic [1:0]  missedSof;
  logic [NUM_EP-1:0] epEvt;

  // Strobes come from the processor clock, so settle them first
  uhi_pin_sync #(
    .WIDTH   ($bits(uhi_pio_s)),
    .RST_VAL (PIO_IDLE)
  ) uPioSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   ({pioCsN, pioRdN, pioWrN, pioAddr, pioDataIn}),
    .settled (pio)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) pioQ <= PIO_IDLE;
    else pioQ <= pio;
  end

  // Act on strobe release using what was held during the strobe
  assign rdFall   = !pio.rdN && pioQ.rdN && !pio.csN;
  assign rdRise   = pio.rdN && !pioQ.rdN && pioDataOe;
  assign wrRise   = pio.wrN && !pioQ.wrN && !pioQ.csN;
  assign hcWrData = wrRise && (pioQ.addr == PORT_HC_DATA);
  assign dcWrData = wrRise && (pioQ.addr == PORT_DC_DATA);
  assign hcRdDone = rdRise && (rdPort == PORT_HC_DATA);
  assign dcRdDone = rdRise && (rdPort == PORT_DC_DATA);

  // Command phase selects the index, each data phase steps the word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hcIdx   <= 8'h00;
      hcPhase <= 1'b0;
    end else if (wrRise && pioQ.addr == PORT_HC_CMD) begin
      hcIdx   <= pioQ.data[7:0];
      hcPhase <= 1'b0;
    end else if (hcWrData || hcRdDone) begin
      hcPhase <= !hcPhase;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dcIdx   <= 8'h00;
      dcPhase <= 1'b0;
    end else if (wrRise && pioQ.addr == PORT_DC_CMD) begin
      dcIdx   <= pioQ.data[7:0];
      dcPhase <= 1'b0;
    end else if (dcWrData || dcRdDone) begin
      dcPhase <= !dcPhase;
    end
  end

  // Host control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hostHwCfg <= HOST_HW_CONFIG_RST;
      hostCpuEn <= 16'h0000;
      hostIntEn <= 32'h0000_0000;
    end else if (hcWrData) begin
      if (hcIdx == IDX_HOST_HW_CONFIG_WR) hostHwCfg <= pioQ.data;
      else if (hcIdx == IDX_HOST_CPU_EN_WR) hostCpuEn <= pioQ.data;
      else if (hcIdx == IDX_HOST_INT_ENABLE_WR && !hcPhase) hostIntEn[15:0] <= pioQ.data;
      else if (hcIdx == IDX_HOST_INT_ENABLE_WR) hostIntEn[31:16] <= pioQ.data;
    end
  end

  // Group 2 events, write one to clear, a new event wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) hostStatus <= 6'h00;
    else if (hcWrData && hcIdx == IDX_HOST_INT_STATUS_WR && !hcPhase)
      hostStatus <= (hostStatus & ~pioQ.data[5:0]) | hostGroup2Evt;
    else hostStatus <= hostStatus | hostGroup2Evt;
  end

  assign group2Sum = (|(hostStatus & hostIntEn[5:0])) & hostIntEn[GROUP2_MASTER_BIT];

  // Group 2 reaches the pin only through the summary flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) hostCpuFlags <= 16'h0000;
    else if (hcWrData && hcIdx == IDX_HOST_CPU_FLAGS_WR)
      hostCpuFlags <= (hostCpuFlags & ~pioQ.data) | {10'h000, group2Sum, hostGroup1Evt};
    else hostCpuFlags <= hostCpuFlags | {10'h000, group2Sum, hostGroup1Evt};
  end

  assign group1Or = |(hostCpuFlags & hostCpuEn);

  // Software may rely on a frozen pin while it reprograms
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) hostLatch <= 1'b0;
    else if (hostHwCfg[HOST_MASTER_EN_BIT]) hostLatch <= group1Or;
  end

  uhi_pulse_gen #(
    .WIDTH_CYC (PULSE_CYC)
  ) uHostPulse (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .level   (hostLatch),
    .pulse   (hostPulse)
  );

  // Device control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      devMode  <= DEV_MODE_RST;
      devHwCfg <= DEV_HW_CONFIG_RST;
      devIntEn <= 32'h0000_0000;
    end else if (dcWrData) begin
      if (dcIdx == IDX_DEV_MODE_WR) devMode <= pioQ.data[7:0];
      else if (dcIdx == IDX_DEV_HW_CONFIG_WR) devHwCfg <= pioQ.data;
      else if (dcIdx == IDX_DEV_INT_EN_WR && !dcPhase) devIntEn[15:0] <= pioQ.data;
      else if (dcIdx == IDX_DEV_INT_EN_WR) devIntEn[31:16] <= pioQ.data;
    end
  end

  // Bus events; reading the low word clears them, a same-cycle event survives
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) devEvFlags <= 6'h00;
    else if (dcRdDone && dcIdx == IDX_DEV_INT_FLAGS_RD && !dcPhase)
      devEvFlags <= (devEvFlags & ~DEV_CLR_ON_READ_MASK[5:0]) |
                    {pseudoTick, sofEvt, eotEvt, suspendEotEvt, resumeEvt, busResetEvt};
    else
      devEvFlags <= devEvFlags |
                    {pseudoTick, sofEvt, eotEvt, suspendEotEvt, resumeEvt, busResetEvt};
  end

  // Endpoint flags, each cleared by reading its own status register
  for (genvar ep = 0; ep < NUM_EP; ep++) begin : gEp
    assign epEvt[ep] = epIsoSel[ep] ? epIsoEvt[ep] : epAckEvt[ep];
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) epFlags[ep] <= 1'b0;
      else if (dcRdDone && dcIdx == IDX_EP_STATUS_BASE + 8'(ep))
        epFlags[ep] <= epEvt[ep];
      else epFlags[ep] <= epFlags[ep] | epEvt[ep];
    end
  end

  // Bus state bit is not stored, reads see the line as it is
  assign devFlagView = {8'h00, epFlags, 1'b0, busSuspended, devEvFlags};

  // Frame watchdog restarted by every frame start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frameCnt   <= '0;
      pseudoTick <= 1'b0;
      missedSof  <= 2'h0;
    end else if (sofEvt) begin
      frameCnt   <= '0;
      pseudoTick <= 1'b0;
      missedSof  <= 2'h0;
    end else if (frameCnt == ($clog2(FRAME_CYCLES))'(FRAME_CYCLES - 1)) begin
      frameCnt   <= '0;
      pseudoTick <= 1'b1;
      if (missedSof != 2'(MISSED_SOF_LIMIT)) missedSof <= missedSof + 2'h1;
    end else begin
      frameCnt   <= frameCnt + 1'b1;
      pseudoTick <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) devSuspendReq <= 1'b0;
    else devSuspendReq <= (missedSof == 2'(MISSED_SOF_LIMIT));
  end

  // Pseudo tick sits at bit 5 and is gated by its own enable
  assign devPending = |(devFlagView & devIntEn);

  // Asserts only while enabled, releases only when flags clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) devActive <= 1'b0;
    else if (!devPending) devActive <= 1'b0;
    else if (devMode[DEV_GLOBAL_EN_BIT]) devActive <= 1'b1;
  end

  uhi_pulse_gen #(
    .WIDTH_CYC (PULSE_CYC)
  ) uDevPulse (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .level   (devActive),
    .pulse   (devPulse)
  );

  // Pin drive per mode; idle level is the inverse of polarity
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) hostIrqPin <= 1'b1;
    else begin
      case (uhi_irq_mode_e'({hostHwCfg[HOST_TRIGGER_BIT], hostHwCfg[HOST_POLARITY_BIT]}))
        MODE_LEVEL_LOW:  hostIrqPin <= !hostLatch;
        MODE_LEVEL_HIGH: hostIrqPin <= hostLatch;
        MODE_EDGE_LOW:   hostIrqPin <= !hostPulse;
        default:         hostIrqPin <= hostPulse;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) deviceIrqPin <= 1'b1;
    else begin
      case (uhi_irq_mode_e'({devHwCfg[DEV_LEVEL_SEL_BIT], devHwCfg[DEV_POLARITY_BIT]}))
        MODE_LEVEL_LOW:  deviceIrqPin <= !devActive;
        MODE_LEVEL_HIGH: deviceIrqPin <= devActive;
        MODE_EDGE_LOW:   deviceIrqPin <= !devPulse;
        default:         deviceIrqPin <= devPulse;
      endcase
    end
  end

  // Read data selection
  always_comb begin
    rdWord = 16'h0000;
    if (pio.addr == PORT_HC_DATA) begin
      if (hcIdx == IDX_HOST_INT_STATUS_RD && !hcPhase) rdWord = {10'h000, hostStatus};
      else if (hcIdx == IDX_HOST_INT_ENABLE_RD && !hcPhase) rdWord = hostIntEn[15:0];
      else if (hcIdx == IDX_HOST_INT_ENABLE_RD) rdWord = hostIntEn[31:16];
      else if (hcIdx == IDX_HOST_HW_CONFIG_RD) rdWord = hostHwCfg;
      else if (hcIdx == IDX_HOST_CPU_FLAGS_RD) rdWord = hostCpuFlags;
      else if (hcIdx == IDX_HOST_CPU_EN_RD) rdWord = hostCpuEn;
    end else if (pio.addr == PORT_DC_DATA) begin
      if (dcIdx == IDX_DEV_MODE_RD) rdWord = {8'h00, devMode};
      else if (dcIdx == IDX_DEV_HW_CONFIG_RD) rdWord = devHwCfg;
      else if (dcIdx == IDX_DEV_INT_EN_RD && !dcPhase) rdWord = devIntEn[15:0];
      else if (dcIdx == IDX_DEV_INT_EN_RD) rdWord = devIntEn[31:16];
      else if (dcIdx == IDX_DEV_INT_FLAGS_RD && !dcPhase) rdWord = devFlagView[15:0];
      else if (dcIdx == IDX_DEV_INT_FLAGS_RD) rdWord = devFlagView[31:16];
      else if (dcIdx[7:4] == IDX_EP_STATUS_BASE[7:4]) rdWord = {15'h0000, epFlags[dcIdx[3:0]]};
    end
  end

  // Word is frozen at the strobe start so a clear cannot tear it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pioDataOut <= 16'h0000;
      pioDataOe  <= 1'b0;
      rdPort     <= 2'h0;
    end else if (rdFall && !pio.addr[0]) begin
      pioDataOut <= rdWord;
      pioDataOe  <= 1'b1;
      rdPort     <= pio.addr;
    end else if (pio.rdN || pio.csN) begin
      pioDataOe  <= 1'b0;
    end
  end
endmodule : uhi_irq_ctrl
`default_nettype wire

// >>> hw/uhi_pkg.sv
// Overview of operation
// - Four pin modes, mode 0 after reset
// - Host mode from config trigger and polarity
// - CPU event needs enable and master enable
// - Controller status only sets summary bit
// - Gated group-2 OR, master bit 31, sets summary
// - Gated group-1 OR into latch, master bit 0
// - Master enable low freezes host pin
// - Device mode from config; global enable bit
// - Each device event sets own status bit
// - Device pin level low default; 200 ns pulse (166 ns rounded up to 4 clocks)
// - Read clears low byte; endpoint read clears endpoint
// - Bus status bit is live
// - Non-iso endpoints interrupt after acknowledge
// - Iso endpoints interrupt every transaction
// - Pseudo frame tick every 1 ms, own enable
// - Three missed frames enter suspend
// - Global enable low: record, no pin
// - Enable high with pending asserts pin
// - Enable low keeps pin until flags clear
`default_nettype none
package uhi_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PULSE_NS      = 166;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_MS      = 1;
  localparam int FRAME_CYC     = FRAME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int MISSED_SOF_LIMIT = 3;
  localparam int NUM_EP        = 16;

  // Port select on the two address lines
  localparam logic [1:0] PORT_HC_DATA = 2'h0;
  localparam logic [1:0] PORT_HC_CMD  = 2'h1;
  localparam logic [1:0] PORT_DC_DATA = 2'h2;
  localparam logic [1:0] PORT_DC_CMD  = 2'h3;

  // Host side indices
  localparam logic [7:0] IDX_HOST_INT_STATUS_RD = 8'h03;
  localparam logic [7:0] IDX_HOST_INT_STATUS_WR = 8'h83;
  localparam logic [7:0] IDX_HOST_INT_ENABLE_RD = 8'h04;
  localparam logic [7:0] IDX_HOST_INT_ENABLE_WR = 8'h84;
  localparam logic [7:0] IDX_HOST_HW_CONFIG_RD  = 8'h20;
  localparam logic [7:0] IDX_HOST_HW_CONFIG_WR  = 8'ha0;
  localparam logic [7:0] IDX_HOST_CPU_FLAGS_RD  = 8'h24;
  localparam logic [7:0] IDX_HOST_CPU_FLAGS_WR  = 8'ha4;
  localparam logic [7:0] IDX_HOST_CPU_EN_RD     = 8'h25;
  localparam logic [7:0] IDX_HOST_CPU_EN_WR     = 8'ha5;
  // Device side indices
  localparam logic [7:0] IDX_DEV_MODE_RD     = 8'hb9;
  localparam logic [7:0] IDX_DEV_MODE_WR     = 8'hb8;
  localparam logic [7:0] IDX_DEV_HW_CONFIG_RD = 8'hbb;
  localparam logic [7:0] IDX_DEV_HW_CONFIG_WR = 8'hba;
  localparam logic [7:0] IDX_DEV_INT_EN_RD   = 8'hc3;
  localparam logic [7:0] IDX_DEV_INT_EN_WR   = 8'hc2;
  localparam logic [7:0] IDX_DEV_INT_FLAGS_RD = 8'hc0;
  localparam logic [7:0] IDX_EP_STATUS_BASE  = 8'h50;

  // Field positions
  localparam int HOST_MASTER_EN_BIT  = 0;
  localparam int HOST_TRIGGER_BIT    = 1;
  localparam int HOST_POLARITY_BIT   = 2;
  localparam int GROUP2_MASTER_BIT   = 31;
  localparam int OP_SUMMARY_BIT      = 5;
  localparam int DEV_POLARITY_BIT    = 0;
  localparam int DEV_LEVEL_SEL_BIT   = 1;
  localparam int DEV_GLOBAL_EN_BIT   = 3;
  localparam int DEV_BUS_STATE_BIT   = 6;
  localparam int DEV_EP_LSB          = 8;
  localparam logic [7:0] DEV_CLR_ON_READ_MASK = 8'h3f;

  // Reset values
  localparam logic [15:0] HOST_HW_CONFIG_RST = 16'h0000;
  localparam logic [15:0] DEV_HW_CONFIG_RST  = 16'h0000;
  localparam logic [7:0]  DEV_MODE_RST       = 8'h00;

  typedef enum logic [1:0] {
    MODE_LEVEL_LOW  = 2'b00,
    MODE_LEVEL_HIGH = 2'b01,
    MODE_EDGE_LOW   = 2'b10,
    MODE_EDGE_HIGH  = 2'b11
  } uhi_irq_mode_e;

  typedef struct packed {
    logic        csN;
    logic        rdN;
    logic        wrN;
    logic [1:0]  addr;
    logic [15:0] data;
  } uhi_pio_s;

  localparam uhi_pio_s PIO_IDLE = '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, addr: 2'h0, data: 16'h0000};
endpackage : uhi_pkg
`default_nettype wire

// >>> hw/uhi_pin_sync.sv
`default_nettype none
module uhi_pin_sync
  import uhi_pkg::*;
#(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Pins and settled copy
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] settled
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Only accept once two later stages agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) settled <= RST_VAL;
    else if (stage2 == stage3) settled <= stage3;
  end
endmodule : uhi_pin_sync
`default_nettype wire

// >>> hw/uhi_pulse_gen.sv
`default_nettype none
module uhi_pulse_gen
  import uhi_pkg::*;
#(
  parameter int WIDTH_CYC = PULSE_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Level in, fixed pulse out
  input  wire logic level,
  output logic      pulse
);
  logic                         levelQ;
  logic [$clog2(WIDTH_CYC+1)-1:0] remain;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) levelQ <= 1'b0;
    else levelQ <= level;
  end

  // A new rising edge during a pulse restarts it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      remain <= '0;
      pulse  <= 1'b0;
    end else if (level && !levelQ) begin
      remain <= ($clog2(WIDTH_CYC+1))'(WIDTH_CYC - 1);
      pulse  <= 1'b1;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end else begin
      pulse  <= 1'b0;
    end
  end
endmodule : uhi_pulse_gen
`default_nettype wire

// >>> verification/uhi_cpu_model.sv
`default_nettype none
module uhi_cpu_model
  import uhi_pkg::*;
(
  // Clock
  input  wire logic        clk_sys,
  // Read answer
  input  wire logic [15:0] pioDataOut,
  input  wire logic        pioDataOe,
  // Strobes and bus
  output var  uhi_pio_s    pio
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pio = PIO_IDLE;
  // Seven cycles low and high, well past the three-flop synchroniser
  task automatic cyc(input logic [1:0] a, input logic rd, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk_sys);
    #2;
    pio.csN  = 1'b0;
    pio.addr = a;
    pio.data = rd ? ~pio.data : d;
    pio.rdN  = !rd;
    pio.wrN  = rd;
    repeat (7) @(posedge clk_sys);
    q = pioDataOe ? pioDataOut : 16'hffff;
    #2;
    pio.csN  = 1'b1;
    pio.rdN  = 1'b1;
    pio.wrN  = 1'b1;
    // Released bus must not keep the last value
    pio.data = ~pio.data;
    repeat (7) @(posedge clk_sys);
    // Return off the edge so callers never race the design's updates
    #2;
  endtask : cyc
endmodule : uhi_cpu_model
`default_nettype wire

// >>> verification/uhi_irq_chk.sv
`default_nettype none
module uhi_irq_chk
  import uhi_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_CYC
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // Processor port
  input wire logic       pioCsN,
  input wire logic       pioRdN,
  input wire logic [1:0] pioAddr,
  input wire logic       pioDataOe,
  // Frame and pins
  input wire logic       sofEvt,
  input wire logic       hostIrqPin,
  input wire logic       deviceIrqPin,
  input wire logic       devSuspendReq
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SUSP_CYC = MISSED_SOF_LIMIT * FRAME_CYCLES;
  int unsigned sinceSof;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Saturates so a long run cannot wrap into a false match
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) sinceSof <= 0;
    else if (sofEvt) sinceSof <= 0;
    else if (sinceSof < 32'hffff) sinceSof <= sinceSof + 1;
  end
  a_reset_pins_idle: assert property (disable iff (1'b0) !rst_n |-> hostIrqPin
    && deviceIrqPin && !pioDataOe && !devSuspendReq) else $error("pins busy in reset");
  a_release_pins_idle: assert property ($rose(rst_n) |-> hostIrqPin
    && deviceIrqPin && !devSuspendReq) else $error("pins busy after reset");
  a_oe_needs_read: assert property ($rose(pioDataOe) |-> $past(!pioRdN, 2))
    else $error("bus driven without read");
  a_oe_needs_select: assert property ($rose(pioDataOe) |-> $past(!pioCsN, 2))
    else $error("bus driven without select");
  a_oe_data_port: assert property ($rose(pioDataOe) |-> $past(!pioAddr[0], 2))
    else $error("command port read answered");
  a_oe_release: assert property ($rose(pioRdN) |-> ##[1:6] !pioDataOe)
    else $error("bus not released");
  a_susp_not_early: assert property ($rose(devSuspendReq) |-> sinceSof >= SUSP_CYC - 2)
    else $error("suspend too early");
  a_susp_in_time: assert property (sinceSof == SUSP_CYC + 3 |-> devSuspendReq)
    else $error("suspend too late");
  a_susp_sof_clears: assert property (sofEvt |-> ##[1:2] !devSuspendReq)
    else $error("suspend kept after frame start");
  a_susp_no_sof: assert property ($rose(devSuspendReq) |-> !$past(sofEvt))
    else $error("suspend despite frame start");
  c_read: cover property ($rose(pioDataOe));
  c_susp: cover property ($rose(devSuspendReq));
  c_dev_irq: cover property ($fell(deviceIrqPin));
  c_host_irq: cover property ($fell(hostIrqPin));
endmodule : uhi_irq_chk
`default_nettype wire

// >>> verification/test_usb_host_device_irq_logic.sv
`default_nettype none
module test_usb_host_device_irq_logic
  import uhi_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FC = 20;
  localparam logic [1:0] HC = PORT_HC_CMD;
  localparam logic [1:0] DC = PORT_DC_CMD;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b1;
  uhi_pio_s          pio;
  logic [15:0]       pioDataOut;
  logic              pioDataOe, hostIrqPin, deviceIrqPin, devSuspendReq;
  logic [5:0]        g2 = '0;
  logic [4:0]        g1 = '0;
  // Bus reset, resume, suspend end, transfer end, frame start
  logic [4:0]        dEvt = '0;
  logic              busSusp = 1'b0;
  logic [NUM_EP-1:0] epAck = '0, epIso = '0, isoSel = '0;
  logic [31:0]       q;
  int                error_cnt = 0, tests_run = 0, m, ep;
  always #25 clk_sys = ~clk_sys;
  uhi_cpu_model cpu_i (.clk_sys(clk_sys), .pioDataOut(pioDataOut), .pioDataOe(pioDataOe),
    .pio(pio));
  uhi_irq_ctrl #(.FRAME_CYCLES(FC)) uhi_irq_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .pioCsN(pio.csN), .pioRdN(pio.rdN), .pioWrN(pio.wrN), .pioAddr(pio.addr),
    .pioDataIn(pio.data), .pioDataOut(pioDataOut), .pioDataOe(pioDataOe),
    .hostGroup2Evt(g2), .hostGroup1Evt(g1), .busResetEvt(dEvt[0]), .resumeEvt(dEvt[1]),
    .suspendEotEvt(dEvt[2]), .eotEvt(dEvt[3]), .sofEvt(dEvt[4]), .busSuspended(busSusp),
    .epAckEvt(epAck), .epIsoEvt(epIso), .epIsoSel(isoSel), .hostIrqPin(hostIrqPin),
    .deviceIrqPin(deviceIrqPin), .devSuspendReq(devSuspendReq));
  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic w(input logic [1:0] cp, input logic [7:0] ix, input logic [31:0] v,
                   input logic two);
    logic [15:0] x;
    cpu_i.cyc(cp, 1'b0, {8'h00, ix}, x);
    cpu_i.cyc({cp[1], 1'b0}, 1'b0, v[15:0], x);
    if (two) cpu_i.cyc({cp[1], 1'b0}, 1'b0, v[31:16], x);
  endtask : w
  task automatic r(input logic [1:0] cp, input logic [7:0] ix, input logic two);
    logic [15:0] x;
    cpu_i.cyc(cp, 1'b0, {8'h00, ix}, x);
    cpu_i.cyc({cp[1], 1'b0}, 1'b1, 16'h0000, q[15:0]);
    q[31:16] = 16'h0000;
    if (two) cpu_i.cyc({cp[1], 1'b0}, 1'b1, 16'h0000, q[31:16]);
  endtask : r
  // One-cycle event pulse, then a settling wait for the pins
  task automatic ev(input int g, input int b, input int wt);
    case (g)
      0: g1[b] = 1'b1;
      1: g2[b] = 1'b1;
      2: dEvt[b] = 1'b1;
      3: epAck[b] = 1'b1;
      default: epIso[b] = 1'b1;
    endcase
    tick(1);
    {g1, g2, dEvt, epAck, epIso} = '0;
    tick(wt);
  endtask : ev
  // Width of the next pulse away from the idle level, bounded
  task automatic pw(input logic dev, input logic idle, output int n);
    int t;
    t = 0;
    n = 0;
    while ((dev ? deviceIrqPin : hostIrqPin) === idle && t < 40) begin
      tick(1);
      t++;
    end
    while ((dev ? deviceIrqPin : hostIrqPin) !== idle && n < 40) begin
      tick(1);
      n++;
    end
    if (t == 40 || n == 40) begin
      chk("pulse wait", 0, 1);
      report_and_stop();
    end
  endtask : pw
  initial begin
    m = $urandom(15876);
    // A real falling edge, so the asynchronous reset acts before the first clock
    #1 rst_n = 1'b0;
    tick(16);
    rst_n = 1'b1;
    tick(4);
    chk("host pin", 1, hostIrqPin);
    chk("dev pin", 1, deviceIrqPin);
    r(HC, 8'h20, 0);
    chk("host cfg", HOST_HW_CONFIG_RST, q);
    r(DC, 8'hbb, 0);
    chk("dev cfg", DEV_HW_CONFIG_RST, q);
    r(HC, 8'h7e, 0);
    chk("unmapped", 0, q);
    cpu_i.cyc(HC, 1'b1, 16'h0000, q[15:0]);
    chk("cmd read", 16'hffff, q[15:0]);
    m = $urandom_range(4, 0);
    w(HC, 8'ha5, 1 << m, 0);
    ev(0, m, 4);
    chk("master off", 1, hostIrqPin);
    w(HC, 8'ha0, 1, 0);
    tick(4);
    chk("master on", 0, hostIrqPin);
    w(HC, 8'ha0, 0, 0);
    w(HC, 8'ha4, 32'h1f, 0);
    tick(4);
    chk("frozen", 0, hostIrqPin);
    w(HC, 8'ha0, 1, 0);
    tick(4);
    chk("unfrozen", 1, hostIrqPin);
    ev(0, m, 4);
    w(HC, 8'ha5, 0, 0);
    w(HC, 8'ha0, 0, 0);
    r(HC, 8'h24, 0);
    chk("flags kept", 1 << m, q);
    chk("masked", 1, hostIrqPin);
    w(HC, 8'ha5, 1 << m, 0);
    w(HC, 8'ha0, 1, 0);
    tick(4);
    chk("restored", 0, hostIrqPin);
    w(HC, 8'ha4, 1 << m, 0);
    m = $urandom_range(5, 0);
    w(HC, 8'ha5, 32'h20, 0);
    w(HC, 8'h84, 1 << m, 1);
    ev(1, m, 4);
    r(HC, 8'h24, 0);
    chk("summary gated", 0, q);
    w(HC, 8'h84, 32'h8000_0000 | (1 << m), 1);
    tick(4);
    r(HC, 8'h24, 0);
    chk("summary set", 32'h20, q);
    chk("g2 pin", 0, hostIrqPin);
    w(HC, 8'ha5, 0, 0);
    tick(4);
    chk("status no pin", 1, hostIrqPin);
    w(HC, 8'h83, 1 << m, 0);
    w(HC, 8'ha4, 32'h20, 0);
    w(HC, 8'ha5, 1, 0);
    for (int k = 1; k < 4; k++) begin
      w(HC, 8'ha0, 32'(1 + 2 * (k / 2) + 4 * (k % 2)), 0);
      tick(4);
      chk("host idle", !k[0], hostIrqPin);
      ev(0, 0, k[1] ? 0 : 4);
      if (k[1]) begin
        pw(1'b0, !k[0], m);
        chk("host pulse", PULSE_CYC, m);
      end else chk("host level", k[0], hostIrqPin);
      w(HC, 8'ha4, 1, 0);
    end
    w(HC, 8'ha0, 1, 0);
    w(DC, 8'hc2, 32'h1f, 1);
    w(DC, 8'hb8, 8, 0);
    for (int k = 0; k < 5; k++) begin
      ev(2, k, 4);
      chk("dev event", 0, deviceIrqPin);
      r(DC, 8'hc0, 1);
      chk("dev flag", 1 << k, q & 32'h1f);
      chk("dev cleared", 1, deviceIrqPin);
    end
    w(DC, 8'hb8, 0, 0);
    ev(2, 4, 4);
    chk("global off", 1, deviceIrqPin);
    w(DC, 8'hb8, 8, 0);
    chk("global on", 0, deviceIrqPin);
    w(DC, 8'hb8, 0, 0);
    chk("global held", 0, deviceIrqPin);
    w(DC, 8'hb8, 8, 0);
    r(DC, 8'hc0, 1);
    chk("dev released", 1, deviceIrqPin);
    ep = $urandom_range(15, 0);
    w(DC, 8'hc2, 32'h100 << ep, 1);
    ev(4, ep, 4);
    chk("no ack", 1, deviceIrqPin);
    ev(3, ep, 4);
    chk("acked", 0, deviceIrqPin);
    r(DC, 8'hc0, 1);
    chk("ep flag", 32'h100 << ep, q & 32'hffff00);
    chk("ep kept", 0, deviceIrqPin);
    r(DC, 8'(8'h50 + ep), 0);
    chk("ep status", 1, q & 1);
    chk("ep cleared", 1, deviceIrqPin);
    isoSel[ep] = 1'b1;
    ev(4, ep, 4);
    chk("iso any", 0, deviceIrqPin);
    r(DC, 8'(8'h50 + ep), 0);
    for (int k = 1; k >= 0; k--) begin
      busSusp = k[0];
      tick(4);
      r(DC, 8'hc0, 0);
      chk("bus state", k[0], q[6]);
    end
    w(DC, 8'hc2, 32'h10, 1);
    for (int k = 1; k < 4; k++) begin
      w(DC, 8'hba, k, 0);
      ev(2, 4, k[1] ? 0 : 4);
      if (k[1]) begin
        pw(1'b1, !k[0], m);
        chk("dev pulse", PULSE_CYC, m);
      end else chk("dev level", k[0], deviceIrqPin);
      r(DC, 8'hc0, 0);
      chk("dev idle", !k[0], deviceIrqPin);
    end
    w(DC, 8'hba, 0, 0);
    w(DC, 8'hc2, 32'h20, 1);
    tick(4 * FC);
    chk("suspend", 1, devSuspendReq);
    chk("pseudo tick", 0, deviceIrqPin);
    ev(2, 4, 4);
    chk("resumed", 0, devSuspendReq);
    w(DC, 8'hc2, 0, 1);
    chk("tick gated", 1, deviceIrqPin);
    report_and_stop();
  end
endmodule : test_usb_host_device_irq_logic
bind uhi_irq_ctrl uhi_irq_chk #(.FRAME_CYCLES(FRAME_CYCLES)) uhi_irq_chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .pioCsN(pioCsN), .pioRdN(pioRdN), .pioAddr(pioAddr),
  .pioDataOe(pioDataOe), .sofEvt(sofEvt), .hostIrqPin(hostIrqPin),
  .deviceIrqPin(deviceIrqPin), .devSuspendReq(devSuspendReq));
`default_nettype wire
